// >>> core/adc_calibration_correction.sv
// Purpose: Offset/gain correction, PGA and unipolar scaling, calibration
// Assumes: raw_valid pulses once per finished filter conversion
// Notes: Result and correction registers are plain ports
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_correction
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Decimation filter output
	input  wire logic [23:0] raw_data,
	input  wire logic        raw_valid,
	// Conversion mode
	input  wire logic        unipolar,
	input  wire logic [1:0]  pga_gain,
	// Calibration request
	input  wire logic        cal_start,
	input  wire logic [1:0]  cal_kind,
	output logic             cal_busy,
	output logic             short_inputs,
	output logic             ref_to_input,
	// Correction register access
	input  wire logic        offset_wr,
	input  wire logic [23:0] offset_wdata,
	input  wire logic        gain_wr,
	input  wire logic [23:0] gain_wdata,
	output logic      [23:0] offset_correction,
	output logic      [23:0] gain_correction,
	// Result
	output logic      [15:0] result,
	output logic             result_valid
);
	typedef struct packed {
		adc_corr_pkg::cal_state_t st;
		logic [1:0]  kind;
		logic [23:0] offset;
		logic [23:0] gain;
		logic [15:0] result;
		logic        result_valid;
		logic        div_go;
		logic [23:0] divisor;
	} core_state_t;

	core_state_t s;
	core_state_t next_s;

	logic signed [24:0] diff;
	logic signed [49:0] prod;
	logic signed [49:0] corr;
	logic signed [53:0] scaled;
	logic        [2:0]  shift;
	logic        [23:0] sat;
	logic               div_busy;
	logic               div_done;
	logic        [46:0] quotient;
	logic               is_gain_cal;

	// Correction datapath
	always_comb
	begin
		diff   = $signed({raw_data[23], raw_data}) - $signed({s.offset[23], s.offset});
		prod   = diff * $signed({1'b0, s.gain});
		corr   = prod >>> adc_corr_pkg::GAIN_FRAC;
		shift  = {1'b0, pga_gain} + {2'b00, unipolar};
		scaled = $signed({{4{corr[49]}}, corr}) <<< shift;
		if (unipolar)
		begin
			if (scaled < 0)
				sat = adc_corr_pkg::UNI_MIN;
			else if (scaled > adc_corr_pkg::SAT_UNI_HI)
				sat = adc_corr_pkg::UNI_MAX;
			else
				sat = scaled[23:0];
		end
		else
		begin
			if (scaled > adc_corr_pkg::SAT_BIP_HI)
				sat = adc_corr_pkg::BIP_MAX;
			else if (scaled < adc_corr_pkg::SAT_BIP_LO)
				sat = adc_corr_pkg::BIP_MIN;
			else
				sat = scaled[23:0];
		end
	end

	assign is_gain_cal = (s.kind == adc_corr_pkg::CAL_SELF_GAIN)
		|| (s.kind == adc_corr_pkg::CAL_SYS_GAIN);

	// Calibration sequencing and register update
	always_comb
	begin
		next_s = s;
		next_s.result_valid = 1'b0;
		next_s.div_go = 1'b0;
		if (offset_wr)
			next_s.offset = offset_wdata;
		if (gain_wr)
			next_s.gain = gain_wdata;
		case (s.st)
			adc_corr_pkg::CAL_IDLE:
			begin
				if (raw_valid)
				begin
					next_s.result = sat[23:8];
					next_s.result_valid = 1'b1;
				end
				if (cal_start)
				begin
					next_s.kind = cal_kind;
					next_s.st = adc_corr_pkg::CAL_SETTLE;
				end
			end
			adc_corr_pkg::CAL_SETTLE:
			begin
				// First conversion may straddle the input switch
				if (raw_valid)
					next_s.st = adc_corr_pkg::CAL_SAMPLE;
			end
			adc_corr_pkg::CAL_SAMPLE:
			begin
				if (raw_valid)
				begin
					if (!is_gain_cal)
					begin
						next_s.offset = raw_data;
						next_s.st = adc_corr_pkg::CAL_IDLE;
					end
					else if (diff > 0)
					begin
						next_s.divisor = diff[23:0];
						next_s.div_go = 1'b1;
						next_s.st = adc_corr_pkg::CAL_DIVIDE;
					end
					else
					begin
						next_s.gain = adc_corr_pkg::GAIN_MAX;
						next_s.st = adc_corr_pkg::CAL_IDLE;
					end
				end
			end
			adc_corr_pkg::CAL_DIVIDE:
			begin
				if (div_done)
				begin
					if (quotient > {23'h000000, adc_corr_pkg::GAIN_MAX})
						next_s.gain = adc_corr_pkg::GAIN_MAX;
					else
						next_s.gain = quotient[23:0];
					next_s.st = adc_corr_pkg::CAL_IDLE;
				end
			end
			default:
			begin
				next_s.st = adc_corr_pkg::CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= adc_corr_pkg::CAL_IDLE;
			s.offset <= adc_corr_pkg::OFFSET_RESET;
			s.gain <= adc_corr_pkg::GAIN_RESET;
		end
		else
			s <= next_s;
	end

	gain_divider u_div
	(
		.clk_sys  (clk_sys),
		.rst      (rst),
		.start    (s.div_go),
		.dividend (adc_corr_pkg::GAIN_DIVIDEND),
		.divisor  (s.divisor),
		.busy     (div_busy),
		.done     (div_done),
		.quotient (quotient)
	);

	assign cal_busy          = (s.st != adc_corr_pkg::CAL_IDLE);
	assign short_inputs      = cal_busy && (s.kind == adc_corr_pkg::CAL_SELF_OFFSET);
	assign ref_to_input      = cal_busy && (s.kind == adc_corr_pkg::CAL_SELF_GAIN);
	assign offset_correction = s.offset;
	assign gain_correction   = s.gain;
	assign result            = s.result;
	assign result_valid      = s.result_valid;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_cal_request;
		!cal_busy && cal_start;
	endsequence

	sequence s_cal_sample;
		s.st == adc_corr_pkg::CAL_SAMPLE && raw_valid && !offset_wr;
	endsequence

	a_reset_values: assert property ($fell(rst) |-> offset_correction == adc_corr_pkg::OFFSET_RESET
		&& gain_correction == adc_corr_pkg::GAIN_RESET)
		else $error("correction registers not at reset values");

	a_div_owner: assert property (div_busy |-> s.st == adc_corr_pkg::CAL_DIVIDE)
		else $error("divider running outside gain calibration");

	a_result_hold: assert property (!(raw_valid && !cal_busy) |=> $stable(result))
		else $error("result changed without a conversion");

	a_unity_pass: assert property (raw_valid && !cal_busy && !unipolar && pga_gain == 2'h0
		&& offset_correction == 24'h000000 && gain_correction == 24'h800000
		|=> result == $past(raw_data[23:8]) && result_valid)
		else $error("unity correction did not pass raw data");

	a_unipolar_clamp: assert property (raw_valid && !cal_busy && unipolar && diff < 0
		|=> result == 16'h0000)
		else $error("negative unipolar value not clamped");

	a_bipolar_sat: assert property (raw_valid && !cal_busy && !unipolar
		&& scaled > adc_corr_pkg::SAT_BIP_HI |=> result == 16'h7FFF)
		else $error("bipolar overflow not saturated");

	a_pga_double: assert property (raw_valid && !cal_busy && !unipolar && pga_gain == 2'h1
		&& offset_correction == 24'h000000 && gain_correction == 24'h800000
		&& raw_data[23:22] == 2'b00 |=> result == $past(raw_data[22:7]))
		else $error("PGA gain of two not applied");

	a_self_offset: assert property (s_cal_sample and (s.kind == adc_corr_pkg::CAL_SELF_OFFSET)
		|=> offset_correction == $past(raw_data) && !cal_busy)
		else $error("self offset not stored");

	a_input_switch: assert property (cal_busy |-> short_inputs
		== (s.kind == adc_corr_pkg::CAL_SELF_OFFSET) && ref_to_input
		== (s.kind == adc_corr_pkg::CAL_SELF_GAIN))
		else $error("input switch wrong for calibration kind");

	a_cal_start: assert property (s_cal_request |=> cal_busy && s.kind == $past(cal_kind))
		else $error("calibration not started");

	a_gain_finish: assert property (s.div_go |-> ##[48:49] !cal_busy)
		else $error("gain calibration did not complete");
endmodule // adc_calibration_correction
`default_nettype wire

// >>> core/adc_corr_pkg.sv
// Purpose: Constants and types for the converter correction stage
// Assumes: 24-bit bipolar decimation filter output, 25 MHz clk_sys
// Notes: Notes on behaviour list below
// Notes on behaviour
// - Internal result is 24-bit, signed bipolar or straight binary unipolar
// - Offset and gain corrections are 24 bits each
// - Reset loads offset zero, gain unity
// - Unipolar and PGA gain applied digitally after correction
// - Unipolar clamps negatives to zero, doubles result
// - Self offset: short inputs, store raw output
// - Self gain: reference in, store reciprocal of difference
// - Self calibration runs automatically, results then applied
// - System calibration measures user zero and full scale
// - Offset correction is two's complement
// - Gain correction is unsigned 1.23 fixed point
// - Result changes only when a conversion completes
// - Straight binary unipolar, two's complement bipolar
// - Sixteen-bit result over the full code range
package adc_corr_pkg;
	localparam int DATA_W      = 24;
	localparam int RESULT_W    = 16;
	localparam int GAIN_FRAC   = 23;
	localparam int DIVIDEND_W  = 47;
	localparam int DIV_STEPS   = 47;
	localparam int SCALED_W    = 54;

	localparam logic [23:0] OFFSET_RESET = 24'h000000;
	localparam logic [23:0] GAIN_RESET   = 24'h800000;
	localparam logic [23:0] GAIN_MAX     = 24'hFFFFFF;
	localparam logic [23:0] BIP_MAX      = 24'h7FFFFF;
	localparam logic [23:0] BIP_MIN      = 24'h800000;
	localparam logic [23:0] UNI_MAX      = 24'hFFFFFF;
	localparam logic [23:0] UNI_MIN      = 24'h000000;
	localparam logic [46:0] GAIN_DIVIDEND = 47'h400000000000;
	localparam logic [5:0]  DIV_LAST     = 6'h2E;

	localparam logic signed [53:0] SAT_BIP_HI = 54'sh00000007FFFFF;
	localparam logic signed [53:0] SAT_BIP_LO = -54'sh0000000800000;
	localparam logic signed [53:0] SAT_UNI_HI = 54'sh0000000FFFFFF;

	// Calibration kinds on cal_kind
	localparam logic [1:0] CAL_SELF_OFFSET = 2'h0;
	localparam logic [1:0] CAL_SELF_GAIN   = 2'h1;
	localparam logic [1:0] CAL_SYS_OFFSET  = 2'h2;
	localparam logic [1:0] CAL_SYS_GAIN    = 2'h3;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_SETTLE,
		CAL_SAMPLE,
		CAL_DIVIDE
	} cal_state_t;
endpackage

// >>> core/gain_divider.sv
// Purpose: Restoring divider for the gain reciprocal
// Assumes: divisor nonzero, start only while idle
// Notes: One quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module gain_divider
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Request
	input  wire logic        start,
	input  wire logic [46:0] dividend,
	input  wire logic [23:0] divisor,
	// Answer
	output logic             busy,
	output logic             done,
	output logic      [46:0] quotient
);
	typedef struct packed {
		logic [23:0] rem;
		logic [46:0] quo;
		logic [23:0] den;
		logic [5:0]  cnt;
		logic        busy;
		logic        done;
	} div_state_t;

	div_state_t s;
	div_state_t next_s;
	logic [24:0] rem_sh;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		rem_sh = {s.rem, s.quo[46]};
		if (s.busy)
		begin
			if (rem_sh >= {1'b0, s.den})
			begin
				next_s.rem = 24'(rem_sh - {1'b0, s.den});
				next_s.quo = {s.quo[45:0], 1'b1};
			end
			else
			begin
				next_s.rem = rem_sh[23:0];
				next_s.quo = {s.quo[45:0], 1'b0};
			end
			next_s.cnt = 6'(s.cnt + 6'h01);
			if (s.cnt == adc_corr_pkg::DIV_LAST)
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
		else if (start)
		begin
			next_s.rem  = 24'h000000;
			next_s.quo  = dividend;
			next_s.den  = divisor;
			next_s.cnt  = 6'h00;
			next_s.busy = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign busy     = s.busy;
	assign done     = s.done;
	assign quotient = s.quo;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_div_length: assert property (start && !busy |-> ##48 done)
		else $error("divider did not finish in 48 cycles");
endmodule // gain_divider
`default_nettype wire

// >>> tb/filter_source.sv
// Purpose: Decimation filter stand-in for the correction stage
// Assumes: fixed conversion rate of RATE clocks
// Notes: Switch requests pick zero or reference level
`timescale 1ns/1ps
`default_nettype none
module filter_source
#(
	parameter int          RATE   = 8,
	parameter logic [23:0] ZERO_V = 24'h000100,
	parameter logic [23:0] REF_V  = 24'h600100
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Input switches and user level
	input  wire logic        short_inputs,
	input  wire logic        ref_to_input,
	input  wire logic [23:0] sample,
	// Filter output
	output logic      [23:0] raw_data,
	output logic             raw_valid
);
	int unsigned cnt;
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			cnt <= 0;
			raw_valid <= 1'b0;
			raw_data <= 24'h000000;
		end
		else
		begin
			cnt <= (cnt == RATE - 1) ? 0 : cnt + 1;
			raw_valid <= (cnt == RATE - 1);
			// Data toggles between conversions
			if (cnt == RATE - 1)
				raw_data <= short_inputs ? ZERO_V : ref_to_input ? REF_V : sample;
			else
				raw_data <= ~raw_data;
		end
	end
endmodule // filter_source
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the correction stage
// Assumes: filter source at a fixed rate
// Notes: Expected codes worked out by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        unipolar = 1'b0;
	logic [1:0]  pga_gain = 2'h0;
	logic        cal_start = 1'b0;
	logic [1:0]  cal_kind = 2'h0;
	logic        offset_wr = 1'b0;
	logic        gain_wr = 1'b0;
	logic [23:0] wdata = 24'h000000;
	logic [23:0] sample = 24'h000000;
	logic [23:0] raw_data;
	logic [23:0] offset_correction;
	logic [23:0] gain_correction;
	logic        raw_valid;
	logic        cal_busy;
	logic        short_inputs;
	logic        ref_to_input;
	logic        result_valid;
	logic [15:0] result;
	int          n_errors = 0;
	int          check_count = 0;
	always #20 clk_sys = ~clk_sys;
	filter_source i_filter_source (.clk_sys(clk_sys), .rst(rst), .short_inputs(short_inputs),
		.ref_to_input(ref_to_input), .sample(sample), .raw_data(raw_data), .raw_valid(raw_valid));
	adc_calibration_correction i_adc_calibration_correction (.clk_sys(clk_sys), .rst(rst),
		.raw_data(raw_data), .raw_valid(raw_valid), .unipolar(unipolar), .pga_gain(pga_gain),
		.cal_start(cal_start), .cal_kind(cal_kind), .cal_busy(cal_busy),
		.short_inputs(short_inputs), .ref_to_input(ref_to_input), .offset_wr(offset_wr),
		.offset_wdata(wdata), .gain_wr(gain_wr), .gain_wdata(wdata),
		.offset_correction(offset_correction), .gain_correction(gain_correction),
		.result(result), .result_valid(result_valid));
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_res;
		int i;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk_sys);
			#1;
			if (result_valid === 1'b1)
				break;
		end
		if (i == 40)
		begin
			n_errors++;
			$display("ERROR result_valid expected 1 seen 0");
			end_of_test();
		end
	endtask
	// Second result is sure to carry the new settings
	task automatic conv(input logic u, input logic [1:0] p, input logic [23:0] s,
		input logic [15:0] e);
		@(posedge clk_sys);
		unipolar <= u;
		pga_gain <= p;
		sample <= s;
		wait_res();
		wait_res();
		chk("result", {8'h00, e}, {8'h00, result});
	endtask
	task automatic wreg(input logic g, input logic [23:0] d);
		@(posedge clk_sys);
		offset_wr <= !g;
		gain_wr <= g;
		wdata <= d;
		@(posedge clk_sys);
		offset_wr <= 1'b0;
		gain_wr <= 1'b0;
		#1;
		chk("reg_write", d, g ? gain_correction : offset_correction);
	endtask
	task automatic cal(input logic [1:0] k, input logic [23:0] s, input logic [23:0] e);
		int i;
		int seen;
		seen = 0;
		@(posedge clk_sys);
		cal_start <= 1'b1;
		cal_kind <= k;
		sample <= s;
		@(posedge clk_sys);
		cal_start <= 1'b0;
		#1;
		chk("switches", {21'h0, 1'b1, k == 2'h0, k == 2'h1},
			{21'h0, cal_busy, short_inputs, ref_to_input});
		for (i = 0; i < 400 && cal_busy === 1'b1; i++)
		begin
			@(posedge clk_sys);
			#1;
			if (result_valid === 1'b1)
				seen++;
		end
		if (i == 400)
		begin
			n_errors++;
			$display("ERROR cal_busy expected 0 seen 1");
			end_of_test();
		end
		chk("results_in_cal", 24'h000000, seen[23:0]);
		chk("cal_store", e, k[0] ? gain_correction : offset_correction);
	endtask
	initial
	begin
		logic [23:0] v;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk("offset_rst", 24'h000000, offset_correction);
		chk("gain_rst", 24'h800000, gain_correction);
		chk("result_rst", 24'h000000, {8'h00, result});
		$display("Test reset done");
		wreg(1'b0, 24'h000045);
		for (int p = 0; p < 4; p++)
		begin
			v = 24'h012300 << p;
			conv(1'b0, p[1:0], 24'h012345, v[23:8]);
			v = 24'h012300 << (p + 1);
			conv(1'b1, p[1:0], 24'h012345, v[23:8]);
		end
		$display("Test gain modes done");
		wreg(1'b0, 24'h000000);
		conv(1'b0, 2'h0, 24'h012345, 16'h0123);
		conv(1'b0, 2'h1, 24'h012345, 16'h0246);
		conv(1'b0, 2'h3, 24'h7FFFFF, 16'h7FFF);
		conv(1'b0, 2'h3, 24'h800000, 16'h8000);
		conv(1'b1, 2'h0, 24'hFFFF00, 16'h0000);
		conv(1'b1, 2'h3, 24'h400000, 16'hFFFF);
		wreg(1'b0, 24'hFFFF00);
		conv(1'b0, 2'h0, 24'h000000, 16'h0001);
		wreg(1'b1, 24'h400000);
		conv(1'b0, 2'h0, 24'h1FFF00, 16'h1000);
		$display("Test limits done");
		wreg(1'b0, 24'h000000);
		chk("result_hold", 24'h001000, {8'h00, result});
		wait_res();
		chk("result_new", 24'h000FFF, {8'h00, result});
		$display("Test hold done");
		cal(2'h0, 24'h000000, 24'h000100);
		cal(2'h1, 24'h000000, 24'hAAAAAA);
		conv(1'b0, 2'h0, 24'h300100, 16'h3FFF);
		cal(2'h2, 24'hFFFF00, 24'hFFFF00);
		cal(2'h3, 24'h7FFF00, 24'h800000);
		$display("Test calibration done");
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
